// >>> core/iss_pkg.sv
// iss_pkg: constants, pin group and config layout for the sensor scan control
// assumes: one 40 MHz system clock, pins driven by an external timing controller
// Function
// - dac code is seven config bits
// - one config bit selects dual output stages
// - memory boost follows its control level
// - pixel reset level from active control
// - full reset wins over partial reset
// - shutter polarities: two low, three high
// - frame start loads row address, ends frame
// - row clock rise selects next row
// - line start loads column address, ends line
// - column clock edges give double pixel rate
// - config data shifts on config clock
// - config takes effect on load rise
// - line end pulse, not when windowing
// - frame end pulse, not when windowing
// - config end output shows shifted data
// - row start is config start times two
package iss_pkg;

  localparam int ROW_W = 12;
  localparam int COL_W = 11;
  localparam int DAC_W = 7;
  localparam int ROW_START_W = 10;
  localparam int COL_START_W = 11;
  localparam int CFG_W = DAC_W + 1 + ROW_START_W + COL_START_W;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // config shift register field positions
  localparam int CFG_DAC_LSB = 0;
  localparam int CFG_DUAL_POS = 7;
  localparam int CFG_ROW_LSB = 8;
  localparam int CFG_COL_LSB = 18;

  // register offsets
  localparam logic [ADDR_W-1:0] REG_LAST_ROW = 4'h0;
  localparam logic [ADDR_W-1:0] REG_LAST_COL = 4'h1;
  localparam logic [ADDR_W-1:0] REG_ROW = 4'h2;
  localparam logic [ADDR_W-1:0] REG_COL = 4'h3;
  localparam logic [ADDR_W-1:0] REG_CFG = 4'h4;
  localparam logic [ADDR_W-1:0] REG_FLAGS = 4'h5;

  // values after reset
  localparam logic [ROW_W-1:0] LAST_ROW_RST = 12'h7ff;
  localparam logic [COL_W-1:0] LAST_COL_RST = 11'h7ff;
  localparam logic [CFG_W-1:0] CFG_RST = 29'h0000_0000;

  typedef enum logic [2:0] {
    RST_NONE = 3'b001,
    RST_FULL = 3'b010,
    RST_PARTIAL = 3'b100
  } iss_reset_t;

  typedef struct packed {
    logic fullReset;
    logic partialResetCtrl;
    logic prechargeN;
    logic sampleN;
    logic memoryBoostCtrlN;
    logic frameStart;
    logic rowClock;
    logic lineStart;
    logic columnClock;
    logic cfgData;
    logic cfgClock;
    logic cfgLoad;
    logic columnHoldCtrlN;
    logic rowDeselect;
    logic columnPrechargeN;
    logic averaging;
  } iss_pins_t;

  // idle pin levels: low-active controls parked high
  localparam iss_pins_t PINS_IDLE = 16'h380a;

  typedef struct packed {
    logic [DAC_W-1:0] dacCode;
    logic dualOutput;
    logic [ROW_START_W-1:0] rowStart;
    logic [COL_START_W-1:0] colStart;
  } iss_cfg_t;

endpackage

// >>> core/iss_scan_ctrl.sv
// iss_scan_ctrl: pixel shutter drivers, row/column scan, serial config
// assumes: all sensor pins asynchronous to clk_sys; control pins stable for
// at least three system clocks; column clock at most a quarter of clk_sys
`timescale 1ns/1ps
`default_nettype none
module iss_scan_ctrl
  import iss_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // sensor pins from the timing controller
  input wire iss_pins_t pins,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdata,
  // internal pixel array drives
  output iss_reset_t pixelReset,
  output logic prechargeOn,
  output logic sampleOn,
  output logic memBoostHigh,
  // scan addresses and column controls
  output logic [ROW_W-1:0] rowSel,
  output logic [COL_W-1:0] colSel,
  output logic columnHoldOn,
  output logic columnPrechargeOn,
  output logic rowDeselectOn,
  output logic averagingOn,
  // analog output setup
  output logic [DAC_W-1:0] dacCode,
  output logic dualOutput,
  // test outputs
  output logic lineEos,
  output logic frameEos,
  output logic cfgEos
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers and edge detection

  iss_pins_t meta_q, sync_q, prev_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // idle levels, so no pixel drive flickers on just after reset
      meta_q <= PINS_IDLE;
      sync_q <= PINS_IDLE;
      prev_q <= PINS_IDLE;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  function automatic logic rise(input logic cur, input logic old);
    return cur & ~old;
  endfunction

  logic rowClkRise, colClkEdge, cfgClkRise, cfgLoadRise, frameRise, lineRise;
  assign rowClkRise = rise(sync_q.rowClock, prev_q.rowClock);
  assign colClkEdge = sync_q.columnClock ^ prev_q.columnClock;
  assign cfgClkRise = rise(sync_q.cfgClock, prev_q.cfgClock);
  assign cfgLoadRise = rise(sync_q.cfgLoad, prev_q.cfgLoad);
  assign frameRise = rise(sync_q.frameStart, prev_q.frameStart);
  assign lineRise = rise(sync_q.lineStart, prev_q.lineStart);

  ////////////////////////////////////////////////////////////////////////////
  // pixel shutter drivers

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pixelReset <= RST_NONE;
      prechargeOn <= 1'b0;
      sampleOn <= 1'b0;
      memBoostHigh <= 1'b0;
    end else begin
      if (sync_q.fullReset) begin
        pixelReset <= RST_FULL;
      end else if (sync_q.partialResetCtrl) begin
        pixelReset <= RST_PARTIAL;
      end else begin
        pixelReset <= RST_NONE;
      end
      prechargeOn <= ~sync_q.prechargeN;
      sampleOn <= ~sync_q.sampleN;
      memBoostHigh <= sync_q.memoryBoostCtrlN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // column readout controls, passed on in active-high form

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      columnHoldOn <= 1'b0;
      columnPrechargeOn <= 1'b0;
      rowDeselectOn <= 1'b0;
      averagingOn <= 1'b0;
    end else begin
      columnHoldOn <= ~sync_q.columnHoldCtrlN;
      columnPrechargeOn <= ~sync_q.columnPrechargeN;
      rowDeselectOn <= sync_q.rowDeselect;
      averagingOn <= sync_q.averaging;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial configuration

  logic [CFG_W-1:0] cfgShift_q;
  iss_cfg_t cfg_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfgShift_q <= CFG_RST;
      cfgEos <= 1'b0;
    end else if (cfgClkRise) begin
      cfgShift_q <= {cfgShift_q[CFG_W-2:0], sync_q.cfgData};
      cfgEos <= cfgShift_q[CFG_W-1];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_q <= iss_cfg_t'(CFG_RST);
    end else if (cfgLoadRise) begin
      cfg_q.dacCode <= cfgShift_q[CFG_DAC_LSB +: DAC_W];
      cfg_q.dualOutput <= cfgShift_q[CFG_DUAL_POS];
      cfg_q.rowStart <= cfgShift_q[CFG_ROW_LSB +: ROW_START_W];
      cfg_q.colStart <= cfgShift_q[CFG_COL_LSB +: COL_START_W];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dacCode <= '0;
      dualOutput <= 1'b0;
    end else begin
      dacCode <= cfg_q.dacCode;
      dualOutput <= cfg_q.dualOutput;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // row scan

  logic [ROW_W-1:0] lastRow_q;
  logic [COL_W-1:0] lastCol_q;
  logic [ROW_W-1:0] rowStartAddr;
  logic rowFull_q, colFull_q;

  assign rowStartAddr = ROW_W'({cfg_q.rowStart, 1'b0});

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rowSel <= '0;
      rowFull_q <= 1'b1;
    end else if (sync_q.frameStart) begin
      rowSel <= rowStartAddr;
      if (frameRise) begin
        rowFull_q <= (rowSel == lastRow_q) && (rowStartAddr == '0);
      end
    end else if (rowClkRise && rowSel != lastRow_q) begin
      rowSel <= rowSel + ROW_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frameEos <= 1'b0;
    end else begin
      frameEos <= !sync_q.frameStart && rowClkRise && rowFull_q
        && (rowSel + ROW_W'(1) == lastRow_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // column scan, one step per column clock edge

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      colSel <= '0;
      colFull_q <= 1'b1;
    end else if (sync_q.lineStart) begin
      colSel <= cfg_q.colStart;
      if (lineRise) begin
        colFull_q <= (colSel == lastCol_q) && (cfg_q.colStart == '0);
      end
    end else if (colClkEdge && colSel != lastCol_q) begin
      colSel <= colSel + COL_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lineEos <= 1'b0;
    end else begin
      lineEos <= !sync_q.lineStart && colClkEdge && colFull_q
        && (colSel + COL_W'(1) == lastCol_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lastRow_q <= LAST_ROW_RST;
      lastCol_q <= LAST_COL_RST;
    end else if (regWr) begin
      if (regAddr == REG_LAST_ROW) begin
        lastRow_q <= regWdata[ROW_W-1:0];
      end
      if (regAddr == REG_LAST_COL) begin
        lastCol_q <= regWdata[COL_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regRdata <= '0;
    end else if (regRd) begin
      case (regAddr)
        REG_LAST_ROW: regRdata <= DATA_W'(lastRow_q);
        REG_LAST_COL: regRdata <= DATA_W'(lastCol_q);
        REG_ROW: regRdata <= DATA_W'(rowSel);
        REG_COL: regRdata <= DATA_W'(colSel);
        REG_CFG: regRdata <= DATA_W'({cfg_q.dualOutput, cfg_q.dacCode});
        REG_FLAGS: regRdata <= DATA_W'({colFull_q, rowFull_q});
        default: regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  full_wins_a: assert property (@(posedge clk_sys) disable iff (rst)
    sync_q.fullReset && sync_q.partialResetCtrl |=> pixelReset == RST_FULL)
    else $error("full reset did not win");

  partial_level_a: assert property (@(posedge clk_sys) disable iff (rst)
    !sync_q.fullReset && sync_q.partialResetCtrl |=> pixelReset == RST_PARTIAL)
    else $error("partial reset level missing");

  boost_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(pins.memoryBoostCtrlN) |-> ##3 !memBoostHigh)
    else $error("memory boost not low three cycles after pin fell");

  sample_polarity_a: assert property (@(posedge clk_sys) disable iff (rst)
    (pins.sampleN == 1'b0) [*4] |-> sampleOn)
    else $error("sample not active while pin low");

  frame_load_a: assert property (@(posedge clk_sys) disable iff (rst)
    sync_q.frameStart |=> rowSel == {$past(cfg_q.rowStart), 1'b0})
    else $error("row address not loaded with doubled start");

  row_step_a: assert property (@(posedge clk_sys) disable iff (rst)
    rowClkRise && !sync_q.frameStart && rowSel != lastRow_q
    |=> rowSel == $past(rowSel) + ROW_W'(1))
    else $error("row did not advance");

  col_step_a: assert property (@(posedge clk_sys) disable iff (rst)
    colClkEdge && !sync_q.lineStart && colSel != lastCol_q
    |=> colSel == $past(colSel) + COL_W'(1))
    else $error("column did not advance on clock edge");

  line_load_a: assert property (@(posedge clk_sys) disable iff (rst)
    sync_q.lineStart |=> colSel == $past(cfg_q.colStart))
    else $error("column address not loaded");

  cfg_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !cfgLoadRise |=> $stable(cfg_q))
    else $error("config changed without load rise");

  cfg_shift_a: assert property (@(posedge clk_sys) disable iff (rst)
    cfgClkRise |=> cfgShift_q[0] == $past(sync_q.cfgData))
    else $error("config bit not shifted in");

  eos_window_a: assert property (@(posedge clk_sys) disable iff (rst)
    !colFull_q |-> !lineEos ##1 1'b1)
    else $error("line end pulse while windowing");

  frame_eos_window_a: assert property (@(posedge clk_sys) disable iff (rst)
    !rowFull_q |=> !frameEos)
    else $error("frame end pulse while windowing");

  dac_apply_a: assert property (@(posedge clk_sys) disable iff (rst)
    cfgLoadRise |=> ##1 dacCode == $past(cfgShift_q[CFG_DAC_LSB +: DAC_W], 2))
    else $error("dac code not applied after load");

  cover_frame_c: cover property (@(posedge clk_sys) disable iff (rst) frameEos);
  cover_line_c: cover property (@(posedge clk_sys) disable iff (rst) lineEos);
  cover_both_c: cover property (@(posedge clk_sys) disable iff (rst)
    sync_q.fullReset && sync_q.partialResetCtrl);
  cover_load_c: cover property (@(posedge clk_sys) disable iff (rst) cfgLoadRise);

endmodule // iss_scan_ctrl
`default_nettype wire

// >>> tb/iss_ctrl_model.sv
// iss_ctrl_model: external timing controller driving every sensor pin
// assumes: tasks are entered right after a rising clk_sys edge
`timescale 1ns/1ps
`default_nettype none
module iss_ctrl_model
  import iss_pkg::*;
(
  // clock, one domain for all strobes
  input wire logic clk_sys,
  // pacing: high holds each level longer
  input wire logic slow,
  // sensor pins
  output var iss_pins_t pins
);
  // end-of-scan outputs are never used to pace anything here
  initial pins = PINS_IDLE; // low-active pins idle high

  // each level stands at least 100 ns, a 200 ns link period
  task automatic hold();
    repeat (slow ? 6 : 4) @(posedge clk_sys);
  endtask

  task automatic put(input iss_pins_t v);
    pins <= v;
    hold();
  endtask

  task automatic set(input int idx, input logic v);
    pins[idx] <= v;
    hold();
  endtask

  task automatic pulse(input int idx);
    set(idx, 1'b1);
    set(idx, 0);
  endtask

  // frame start holds one row clock rise inside it
  task automatic frame_start();
    set(10, 1'b1);
    pulse(9);
    set(10, 1'b0);
  endtask
endmodule // iss_ctrl_model
`default_nettype wire

// >>> tb/tb_top.sv
// tb_top: self-checking bench for iss_scan_ctrl
// assumes: iss_ctrl_model drives the pins, bench drives the register port
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import iss_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst;
  logic slow;
  logic regWr;
  logic regRd;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata;
  logic [DATA_W-1:0] regRdata;
  iss_pins_t pins;
  iss_pins_t v;
  iss_reset_t pixelReset;
  logic prechargeOn, sampleOn, memBoostHigh, columnHoldOn, columnPrechargeOn;
  logic rowDeselectOn, averagingOn, dualOutput, lineEos, frameEos, cfgEos;
  logic [ROW_W-1:0] rowSel;
  logic [COL_W-1:0] colSel;
  logic [DAC_W-1:0] dacCode;
  logic [31:0] seed = 32'hc423;
  logic [CFG_W-1:0] shreg = CFG_RST;
  logic [CFG_W-1:0] live = CFG_RST;
  logic [CFG_W-1:0] cfgA, cfgB;
  int errors = 0;
  int tests_run = 0;
  int fEos = 0;
  int lEos = 0;

  always #12.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (frameEos === 1'b1)
      fEos++;
    if (lineEos === 1'b1)
      lEos++;
  end

  iss_scan_ctrl dut (.clk_sys(clk_sys), .rst(rst), .pins(pins), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .pixelReset(pixelReset), .prechargeOn(prechargeOn), .sampleOn(sampleOn),
    .memBoostHigh(memBoostHigh), .rowSel(rowSel), .colSel(colSel),
    .columnHoldOn(columnHoldOn), .columnPrechargeOn(columnPrechargeOn),
    .rowDeselectOn(rowDeselectOn), .averagingOn(averagingOn), .dacCode(dacCode),
    .dualOutput(dualOutput), .lineEos(lineEos), .frameEos(frameEos), .cfgEos(cfgEos));

  iss_ctrl_model ctl (.clk_sys(clk_sys), .slow(slow), .pins(pins));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic iss_reset_t exp_rst(input iss_pins_t p);
    return p.fullReset ? RST_FULL : (p.partialResetCtrl ? RST_PARTIAL : RST_NONE);
  endfunction

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdc(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 chk(what, e, regRdata);
    @(posedge clk_sys);
  endtask

  // shift msb first, then load
  task automatic cfg(input logic [CFG_W-1:0] w);
    for (int i = CFG_W - 1; i >= 0; i--) begin
      ctl.set(6, w[i]);
      ctl.pulse(5);
      chk("cfgEos", shreg[CFG_W-1], cfgEos);
      shreg = {shreg[CFG_W-2:0], w[i]};
    end
    chk("cfg before load", live[7:0], {dualOutput, dacCode});
    ctl.pulse(4);
    live = w;
    chk("cfg after load", live[7:0], {dualOutput, dacCode});
  endtask

  // n row clock rises or column clock edges from start 0
  task automatic scan(input bit row, input int n, input int e);
    int e0;
    e0 = row ? fEos : lEos;
    repeat (n)
      if (row)
        ctl.pulse(9);
      else
        ctl.set(7, !pins.columnClock);
    chk(row ? "rowSel" : "colSel", row ? 5 : 7, row ? 32'(rowSel) : 32'(colSel));
    chk(row ? "frameEos" : "lineEos", e, (row ? fEos : lEos) - e0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk_sys);
    errors++;
    end_sim();
  end

  initial begin
    rst <= 1'b1;
    slow <= 1'b0;
    regWr <= 1'b0;
    regRd <= 1'b0;
    regAddr <= '0;
    regWdata <= '0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rdc("lastRow", REG_LAST_ROW, 16'(LAST_ROW_RST));
    rdc("lastCol", REG_LAST_COL, 16'(LAST_COL_RST));
    rdc("cfgReg", REG_CFG, 16'h0000);
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      v = iss_pins_t'(seed[15:0] & 16'hf80f);
      if (i < 3)
        v[15:14] = 2'b11;
      slow <= seed[20];
      ctl.put(v);
      chk("pixelReset", 32'(exp_rst(v)), 32'(pixelReset));
      chk("levels", {!v.prechargeN, !v.sampleN, v.memoryBoostCtrlN, !v.columnHoldCtrlN,
        v.rowDeselect, !v.columnPrechargeN, v.averaging}, {prechargeOn, sampleOn,
        memBoostHigh, columnHoldOn, rowDeselectOn, columnPrechargeOn, averagingOn});
    end
    wr(REG_LAST_ROW, 16'h0005);
    wr(REG_LAST_COL, 16'h0007);
    wr(REG_ROW, 16'h0abc);
    rdc("lastRow", REG_LAST_ROW, 16'h0005);
    rdc("lastCol", REG_LAST_COL, 16'h0007);
    rdc("unmapped", 4'hf, 16'h0000);
    cfgA = {11'h005, 10'h003, seed[7:0]};
    cfgB = {11'h000, 10'h000, ~seed[7:0]};
    cfg(cfgA);
    rdc("cfgReg", REG_CFG, {8'h00, cfgA[7:0]});
    ctl.frame_start();
    chk("rowStart", 32'h6, 32'(rowSel));
    ctl.pulse(8);
    chk("colStart", 32'h5, 32'(colSel));
    rdc("rowReg", REG_ROW, 16'h0006);
    cfg(cfgB);
    ctl.frame_start();
    ctl.pulse(8);
    scan(1, 5, 0);
    scan(0, 7, 0);
    ctl.frame_start();
    ctl.pulse(8);
    scan(1, 6, 1);
    scan(0, 8, 1);
    rdc("flags", REG_FLAGS, 16'h0003);
    rdc("colReg", REG_COL, 16'h0007);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
